// ===== core/jdcs_defines.svh
// register map, field positions, reset values and timing counts of the drop sequencer
`ifndef JDCS_DEFINES_SVH
`define JDCS_DEFINES_SVH
`define JDCS_NUM_RCP      6
`define JDCS_RCP_STRIDE   8'h10
`define JDCS_OFS_TIME     2'h0
`define JDCS_OFS_COMP     2'h1
`define JDCS_OFS_CNT      2'h2
`define JDCS_OFS_CTRL     8'h60
`define JDCS_OFS_STATUS   8'h64
`define JDCS_OPEN_LSB     0
`define JDCS_CLOSED_LSB   16
`define JDCS_FIRST_LSB    0
`define JDCS_LONG_LSB     8
`define JDCS_IDLE_LSB     16
`define JDCS_COUNT_LSB    0
`define JDCS_HELD_BIT     16
`define JDCS_EN_BIT       0
`define JDCS_RST_OPEN     16'h0014
`define JDCS_RST_CLOSED   16'h001e
`define JDCS_RST_COUNT    16'h0001
`define JDCS_RST_EN       1'b1
`define JDCS_CLK_NS       8
`define JDCS_TICK_NS      100000
`define JDCS_SEC_NS       1000000000
`define JDCS_TICK_CYC     (`JDCS_TICK_NS / `JDCS_CLK_NS)
`define JDCS_SEC_CYC      (`JDCS_SEC_NS / `JDCS_CLK_NS)
`endif

// ===== core/jdcs_pkg.sv
// types of the drop sequencer
package jdcs_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_OPEN, ST_CLOSE} jdcs_state_t;
    typedef struct packed {
        logic [15:0] closed;
        logic [15:0] open_t;
        logic [15:0] idle_sec;
        logic [7:0]  long_extra;
        logic [7:0]  first_extra;
        logic        held;
        logic [15:0] count;
    } jdcs_recipe_t;
endpackage

// ===== core/jdcs_core.sv
// drop cycle sequencer with apb recipe registers
`timescale 1ns/100ps
`include "jdcs_defines.svh"
//Contract
//- burst emits exactly drop_count drops per trigger
//- drop is open interval then closed interval
//- held mode ignores drop_count
//- held mode repeats drops while trigger low
//- trigger edge during a drop is discarded
//- first drop extra chosen by idle time
//- idle time counts since last dispense
//- later burst drops use plain open interval
//- count of one always gets compensation
//- held mode compensates first drop only
//- intervals programmable in 0.1 ms steps
//- active flag high idle, low dispensing
//- six recipes, each on own trigger
//- valve open in open, closed in closed
module jdcs_core
    import jdcs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `JDCS_TICK_CYC,
    parameter int unsigned SEC_CYCLES  = `JDCS_SEC_CYC
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RSTN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [5:0]  TRIG_N,
    output logic             VALVE_OPEN,
    output logic             JET_ACTIVE_FLAG_N
);

    jdcs_recipe_t rcp_q [`JDCS_NUM_RCP];
    jdcs_recipe_t cur;
    jdcs_state_t  state_q;
    logic         ctrl_en_q;
    logic [5:0]   trig_s1_q;
    logic [5:0]   trig_s2_q;
    logic [5:0]   trig_s3_q;
    logic [5:0]   trig_fall;
    logic         pick_ok;
    logic [2:0]   pick_idx;
    logic         go;
    logic         long_now;
    logic [2:0]   idx_q;
    logic [15:0]  rem_q;
    logic         first_q;
    logic         long_q;
    logic         held_q;
    logic         valve_q;
    logic [15:0]  pre_q;
    logic [16:0]  tick_q;
    logic [16:0]  ext;
    logic [16:0]  target;
    logic         phase_done;
    logic         more;
    logic [26:0]  sec_cyc_q;
    logic [15:0]  idle_sec_q;
    logic         wr_en;
    logic         map_ok;
    logic [2:0]   a_rcp;
    logic [1:0]   a_ofs;
    logic [31:0]  rd_d;

    // trigger pins, two-stage sync then one stage for edge detect
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            trig_s1_q <= 6'h3f;
            trig_s2_q <= 6'h3f;
            trig_s3_q <= 6'h3f;
        end else begin
            trig_s1_q <= TRIG_N;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
        end
    end

    assign trig_fall = trig_s3_q & ~trig_s2_q;

    // lowest recipe number wins when triggers coincide
    always_comb begin
        pick_ok  = 1'b0;
        pick_idx = 3'h0;
        for (int i = `JDCS_NUM_RCP - 1; i >= 0; i--) begin
            if (trig_fall[i]) begin
                pick_ok  = 1'b1;
                pick_idx = 3'(i);
            end
        end
    end

    // held recipes start regardless of count; burst needs a nonzero count
    assign go = ctrl_en_q && pick_ok &&
                (rcp_q[pick_idx].held || rcp_q[pick_idx].count != 16'h0000);
    assign long_now = idle_sec_q >= rcp_q[pick_idx].idle_sec;
    assign cur      = rcp_q[idx_q];

    // apb decode, zero wait states
    assign a_rcp  = PADDR[6:4];
    assign a_ofs  = PADDR[3:2];
    assign map_ok = (PADDR[7:4] < 4'(`JDCS_NUM_RCP) && a_ofs != 2'h3) ||
                    PADDR == `JDCS_OFS_CTRL || PADDR == `JDCS_OFS_STATUS;
    assign wr_en  = PSEL && PENABLE && PWRITE && map_ok;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !map_ok;

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_en_q <= `JDCS_RST_EN;
            for (int i = 0; i < `JDCS_NUM_RCP; i++) begin
                rcp_q[i] <= '{closed: `JDCS_RST_CLOSED, open_t: `JDCS_RST_OPEN,
                              count: `JDCS_RST_COUNT, default: '0};
            end
        end else if (wr_en) begin
            if (PADDR == `JDCS_OFS_CTRL) begin
                ctrl_en_q <= PWDATA[`JDCS_EN_BIT];
            end else if (PADDR[7:4] < 4'(`JDCS_NUM_RCP)) begin
                unique case (a_ofs)
                    `JDCS_OFS_TIME: begin
                        rcp_q[a_rcp].open_t <= PWDATA[`JDCS_OPEN_LSB +: 16];
                        rcp_q[a_rcp].closed <= PWDATA[`JDCS_CLOSED_LSB +: 16];
                    end
                    `JDCS_OFS_COMP: begin
                        rcp_q[a_rcp].first_extra <= PWDATA[`JDCS_FIRST_LSB +: 8];
                        rcp_q[a_rcp].long_extra  <= PWDATA[`JDCS_LONG_LSB +: 8];
                        rcp_q[a_rcp].idle_sec    <= PWDATA[`JDCS_IDLE_LSB +: 16];
                    end
                    `JDCS_OFS_CNT: begin
                        rcp_q[a_rcp].count <= PWDATA[`JDCS_COUNT_LSB +: 16];
                        rcp_q[a_rcp].held  <= PWDATA[`JDCS_HELD_BIT];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        if (PADDR == `JDCS_OFS_CTRL) begin
            rd_d[`JDCS_EN_BIT] = ctrl_en_q;
        end else if (PADDR == `JDCS_OFS_STATUS) begin
            rd_d = {idle_sec_q, 8'h00, first_q, idx_q, 2'(state_q), valve_q,
                    ~JET_ACTIVE_FLAG_N};
        end else if (PADDR[7:4] < 4'(`JDCS_NUM_RCP)) begin
            unique case (a_ofs)
                `JDCS_OFS_TIME: rd_d = {rcp_q[a_rcp].closed, rcp_q[a_rcp].open_t};
                `JDCS_OFS_COMP: rd_d = {rcp_q[a_rcp].idle_sec, rcp_q[a_rcp].long_extra,
                                        rcp_q[a_rcp].first_extra};
                `JDCS_OFS_CNT:  rd_d = {15'h0000, rcp_q[a_rcp].held, rcp_q[a_rcp].count};
                default:        rd_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= rd_d;
        end
    end

    // interval length in 0.1 ms ticks, extra only on a first drop
    assign ext = !first_q ? 17'h00000 :
                 long_q ? {9'h000, cur.long_extra} : {9'h000, cur.first_extra};
    assign target = (state_q == ST_OPEN) ? {1'b0, cur.open_t} + ext : {1'b0, cur.closed};
    // >= so an interval shortened by a write mid-drop still ends
    assign phase_done = tick_q >= target;
    // held run stops at a drop end once the synced pin is back high
    assign more = held_q ? (ctrl_en_q && !trig_s2_q[idx_q]) : (rem_q > 16'h0001);

    // tick prescaler restarts at every phase start
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pre_q  <= 16'h0000;
            tick_q <= 17'h00000;
        end else if (state_q == ST_IDLE || phase_done) begin
            pre_q  <= 16'h0000;
            tick_q <= 17'h00000;
        end else if (pre_q == 16'(TICK_CYCLES - 1)) begin
            pre_q  <= 16'h0000;
            tick_q <= tick_q + 17'h00001;
        end else begin
            pre_q <= pre_q + 16'h0001;
        end
    end

    // drop sequencer; trigger edges are only looked at while idle
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= ST_IDLE;
            idx_q   <= 3'h0;
            rem_q   <= 16'h0000;
            first_q <= 1'b0;
            long_q  <= 1'b0;
            held_q  <= 1'b0;
            valve_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (go) begin
                        state_q <= ST_OPEN;
                        idx_q   <= pick_idx;
                        rem_q   <= rcp_q[pick_idx].count;
                        held_q  <= rcp_q[pick_idx].held;
                        first_q <= 1'b1;
                        long_q  <= long_now;
                        valve_q <= 1'b1;
                    end
                end
                ST_OPEN: begin
                    if (phase_done) begin
                        state_q <= ST_CLOSE;
                        valve_q <= 1'b0;
                    end
                end
                ST_CLOSE: begin
                    if (phase_done) begin
                        first_q <= 1'b0;
                        rem_q   <= rem_q - 16'h0001;
                        if (more) begin
                            state_q <= ST_OPEN;
                            valve_q <= 1'b1;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // idle seconds since the last drop ended, saturating
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sec_cyc_q  <= 27'h0000000;
            idle_sec_q <= 16'h0000;
        end else if (state_q != ST_IDLE) begin
            sec_cyc_q  <= 27'h0000000;
            idle_sec_q <= 16'h0000;
        end else if (sec_cyc_q == 27'(SEC_CYCLES - 1)) begin
            sec_cyc_q <= 27'h0000000;
            if (idle_sec_q != 16'hffff) begin
                idle_sec_q <= idle_sec_q + 16'h0001;
            end
        end else begin
            sec_cyc_q <= sec_cyc_q + 27'h0000001;
        end
    end

    assign VALVE_OPEN        = valve_q;
    assign JET_ACTIVE_FLAG_N = state_q == ST_IDLE;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RSTN);

    sequence s_accept;
        state_q == ST_IDLE && go;
    endsequence

    sequence s_drop_end;
        state_q == ST_CLOSE && phase_done;
    endsequence

    property p_valve_phase;
        VALVE_OPEN == (state_q == ST_OPEN);
    endproperty
    a_valve_phase: assert property (p_valve_phase) else $error("valve out of phase");

    property p_flag_idle;
        (JET_ACTIVE_FLAG_N |-> !VALVE_OPEN) and (s_accept |=> !JET_ACTIVE_FLAG_N);
    endproperty
    a_flag_idle: assert property (p_flag_idle) else $error("active flag wrong");

    property p_start_first;
        s_accept |=> state_q == ST_OPEN && first_q && idx_q == $past(pick_idx)
                     && long_q == $past(long_now);
    endproperty
    a_start_first: assert property (p_start_first) else $error("bad drop start");

    property p_busy_ignores;
        state_q != ST_IDLE |=> idx_q == $past(idx_q);
    endproperty
    a_busy_ignores: assert property (p_busy_ignores) else $error("trigger taken busy");

    property p_open_to_close;
        state_q == ST_OPEN && phase_done |=> state_q == ST_CLOSE && tick_q == 17'h00000;
    endproperty
    a_open_to_close: assert property (p_open_to_close) else $error("open not closed");

    property p_tick_restart;
        state_q == ST_IDLE |-> tick_q == 17'h00000 && pre_q == 16'h0000;
    endproperty
    a_tick_restart: assert property (p_tick_restart) else $error("stale tick count");

    property p_burst_end;
        s_drop_end and (!held_q && rem_q == 16'h0001) |=> state_q == ST_IDLE;
    endproperty
    a_burst_end: assert property (p_burst_end) else $error("burst overran");

    property p_burst_more;
        s_drop_end and (!held_q && rem_q > 16'h0001) |=> state_q == ST_OPEN ##0 !first_q;
    endproperty
    a_burst_more: assert property (p_burst_more) else $error("burst cut short");

    property p_held_more;
        s_drop_end and (held_q && ctrl_en_q && !trig_s2_q[idx_q])
            |=> state_q == ST_OPEN && !first_q && ext == 17'h00000;
    endproperty
    a_held_more: assert property (p_held_more) else $error("held drop wrong");

    property p_held_count;
        s_accept and (rcp_q[pick_idx].held && rcp_q[pick_idx].count == 16'h0000)
            |=> state_q == ST_OPEN;
    endproperty
    a_held_count: assert property (p_held_count) else $error("held used count");

    property p_idle_restart;
        s_drop_end and !more |=> idle_sec_q == 16'h0000 ##1 idle_sec_q == 16'h0000;
    endproperty
    a_idle_restart: assert property (p_idle_restart) else $error("idle timer stale");

    // never wraps while idle; a drop start clears it one edge later
    property p_idle_sat;
        state_q == ST_IDLE |=> idle_sec_q >= $past(idle_sec_q);
    endproperty
    a_idle_sat: assert property (p_idle_sat) else $error("idle timer wrapped");

endmodule // jdcs_core

// ===== test/jdcs_robot.sv
// robot side model driving the recipe trigger pins
`timescale 1ns/100ps
module jdcs_robot (
    input  wire logic       clk,
    input  wire logic       busy_n,
    output logic      [5:0] trig_n
);
    initial trig_n = 6'h3f;

    // falling edge, held long enough for the input synchroniser
    task automatic pulse(input int idx, input bit polite);
        int k;
        k = 0;
        while (polite && busy_n !== 1'b1 && k < 5000) begin
            @(posedge clk);
            k++;
        end
        @(posedge clk);
        trig_n[idx] <= 1'b0;
        repeat (4) @(posedge clk);
        trig_n[idx] <= 1'b1;
    endtask

    task automatic hold(input int idx, input bit low);
        @(posedge clk);
        trig_n[idx] <= !low;
    endtask
endmodule // jdcs_robot

// ===== test/jet_drop_cycle_sequencer_bench.sv
// self-checking bench of the drop sequencer
`timescale 1ns/100ps
module jet_drop_cycle_sequencer_bench;
    logic        clk     = 1'b0;
    logic        rstn    = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  trig_n;
    logic        valve;
    logic        busy_n;
    int          fail_count = 0;
    int          n_tests    = 0;
    int          w_o = 0;
    int          w_c = 0;
    int          n_rise = 0;
    int          r;
    int          opens[$];
    int          closes[$];

    always #4 clk = ~clk;

    jdcs_core #(.TICK_CYCLES(4), .SEC_CYCLES(20)) dut (
        .SYS_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TRIG_N(trig_n), .VALVE_OPEN(valve), .JET_ACTIVE_FLAG_N(busy_n)
    );
    jdcs_robot robot (.clk(clk), .busy_n(busy_n), .trig_n(trig_n));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // open and closed widths of each drop, in clock cycles
    always @(posedge clk) begin
        if (valve === 1'b1) begin
            if (w_o == 0) n_rise++;
            w_o++;
            chk("busy_n_while_open", 32'h0, {31'h0, busy_n});
        end else if (w_o != 0) begin
            opens.push_back(w_o);
            w_o = 0;
        end
        if (valve === 1'b0 && busy_n === 1'b0) w_c++;
        else if (w_c != 0) begin
            closes.push_back(w_c);
            w_c = 0;
        end
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, a, d, rd, e);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp,
                         input logic eerr);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, a, 32'h0, rd, e);
        chk(what, exp, rd);
        chk({what, "_err"}, {31'h0, eerr}, {31'h0, e});
    endtask

    task automatic run_done;
        int k;
        k = 0;
        repeat (10) @(posedge clk);
        while (busy_n !== 1'b1 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        repeat (3) @(posedge clk);
    endtask

    // closed width is always one tick of 4 cycles plus one
    task automatic expect_run(input string what, input int n, input int first, input int later);
        chk({what, "_drops"}, n, opens.size());
        chk({what, "_closes"}, n, closes.size());
        for (int i = 0; i < n && i < opens.size() && i < closes.size(); i++) begin
            chk({what, "_open"}, (i == 0) ? first : later, opens[i]);
            chk({what, "_closed"}, 5, closes[i]);
        end
        opens.delete();
        closes.delete();
        n_rise = 0;
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        end_sim();
    end

    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        rdchk("time0", 8'h00, 32'h001e0014, 1'b0);
        rdchk("cnt0", 8'h08, 32'h00000001, 1'b0);
        rdchk("ctrl", 8'h60, 32'h00000001, 1'b0);
        wr(8'h0c, 32'hffffffff);
        rdchk("hole", 8'h0c, 32'h0, 1'b1);
        for (r = 0; r < 6; r++) begin
            wr(8'(r * 16), {16'h0001, 16'(r + 1)});
            robot.pulse(r, 1'b1);
            run_done();
            expect_run("recipe", 1, (r + 1) * 4 + 1, 0);
        end
        wr(8'h10, 32'h00010001);
        wr(8'h14, 32'h00ff0502);
        wr(8'h18, 32'h00000003);
        rdchk("comp1", 8'h14, 32'h00ff0502, 1'b0);
        wr(8'h20, 32'h00010001);
        wr(8'h24, 32'h00010502);
        wr(8'h30, 32'h00010001);
        wr(8'h34, 32'h00ff0502);
        wr(8'h38, 32'h00010000);
        robot.pulse(1, 1'b1);
        while (!(n_rise == 1 && valve === 1'b0)) @(posedge clk);
        rdchk("status_close", 8'h64, 32'h00000099, 1'b0);
        robot.pulse(0, 1'b0);
        run_done();
        expect_run("burst", 3, 13, 5);
        robot.pulse(2, 1'b1);
        run_done();
        expect_run("short_idle", 1, 13, 0);
        repeat (50) @(posedge clk);
        robot.pulse(2, 1'b1);
        run_done();
        expect_run("long_idle", 1, 25, 0);
        robot.hold(3, 1'b1);
        while (n_rise < 3) @(posedge clk);
        robot.hold(3, 1'b0);
        run_done();
        expect_run("held", 3, 13, 5);
        wr(8'h60, 32'h0);
        rdchk("ctrl_off", 8'h60, 32'h0, 1'b0);
        robot.pulse(0, 1'b1);
        repeat (20) @(posedge clk);
        expect_run("disabled", 0, 0, 0);
        wr(8'h60, 32'h1);
        end_sim();
    end
endmodule // jet_drop_cycle_sequencer_bench
